// ---- design/msc_pkg.sv ----
// Shared constants, command and monitoring bit layout, and states for the motor starter.
// Contract
// - Reversing command bits: reverse, off, forward, emergency, auto, reset
// - Reversing monitoring bits, lockout flag, inputs mirrored high
// - Relay c and supply follow command unless fault
// - Star-delta uses relays a, b, c
// - Star-delta: relay c never fault output
// - Star to delta no earlier than one second
// - Changeover by time or current, per mode setting
// - Star-delta monitoring bits and clamped current word
// - Star-delta command bits, only supply bit high
// - Pole-changing: relay a speed one, b two
// - Pole-changing local start one, two, and stop
// - No voltage-dip ride-through in pole-changing mode
// - Optional checkback on digital input zero
// - Star-delta local start and stop inputs
// - Reverse only after off and lockout elapsed
package msc_pkg;
  // Starter modes
  localparam logic [1:0] MODE_REVERSING  = 2'h0;
  localparam logic [1:0] MODE_STAR_DELTA = 2'h1;
  localparam logic [1:0] MODE_POLE       = 2'h2;
  // Fault output selection
  localparam logic [1:0] FAULT_OUT_NONE  = 2'h0;
  localparam logic [1:0] FAULT_OUT_RELAY = 2'h1;
  localparam logic [1:0] FAULT_OUT_AUX   = 2'h2;
  // Command byte 0 bit positions
  localparam int CMD0_RUN_REV   = 0;
  localparam int CMD0_OFF       = 1;
  localparam int CMD0_RUN_FWD   = 2;
  localparam int CMD0_EMERGENCY = 4;
  localparam int CMD0_AUTO      = 5;
  localparam int CMD0_FAULT_RST = 6;
  // Command byte 1 bit positions
  localparam int CMD1_FAST_FWD  = 1;
  localparam int CMD1_AUX_OUT   = 4;
  localparam int CMD1_RELAY_C   = 7;
  // Digital input positions
  localparam int DIN_CHECKBACK  = 0;
  localparam int DIN_SPEED2     = 3;
  localparam int DIN_START      = 4;
  localparam int DIN_STOP       = 5;
  // Monitoring byte 0 bit positions
  localparam int MON0_RUN_REV   = 0;
  localparam int MON0_OFF       = 1;
  localparam int MON0_RUN_FWD   = 2;
  localparam int MON0_OVERLOAD  = 3;
  localparam int MON0_LOCKOUT   = 4;
  localparam int MON0_LOCAL     = 5;
  localparam int MON0_FAULT     = 6;
  localparam int MON0_WARNING   = 7;
  // Monitoring byte 1 position of fast forward
  localparam int MON1_FAST_FWD  = 1;
  // Monitoring byte 1 position of the first mirrored input
  localparam int MON1_DIN_LSB   = 2;
  // Current report ceiling in percent of rated current
  localparam logic [15:0] CURRENT_MAX_PCT = 16'h0320;
  // Timing: one tick is 100 ms at an 8 ns clock
  localparam int CLK_PERIOD_NS   = 8;
  localparam int TICK_PERIOD_MS  = 100;
  localparam int TICK_CYCLES     = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int MIN_START_MS    = 1000;
  localparam logic [7:0] MIN_START_TICKS = 8'(MIN_START_MS / TICK_PERIOD_MS);
  localparam logic [7:0] CHECKBACK_TICKS = 8'h02;
  // Controller states
  typedef enum logic [2:0] {
    st_off, st_fwd, st_rev, st_star, st_delta, st_speed1, st_speed2, st_fault
  } state_e;
endpackage

// ---- design/timer_if.sv ----
// Carrier between the controller and its tick countdown timers.
`timescale 1ns/1ps
`default_nettype none
interface timer_if;
  logic       load;   // Pulse: restart count
  logic [7:0] value;  // Ticks to count
  logic       tick;   // Pulse: one time base step
  logic       busy;   // Level: count not yet at zero
  modport ctrl  (output load, output value, output tick, input busy);
  modport timer (input load, input value, input tick, output busy);
endinterface
`default_nettype wire

// ---- design/tick_countdown.sv ----
// Countdown timer in time base ticks.
`timescale 1ns/1ps
`default_nettype none
module tick_countdown (
  input  wire logic  mclk,
  input  wire logic  rst,
  timer_if.timer     tmr
);
  logic [7:0] count_reg;  // Remaining ticks

  ////////////////////////////////////////////////////////////////////////
  // Load wins over the tick so a restart is never shortened
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count_reg <= 8'h00;
    end else if (tmr.load) begin
      count_reg <= tmr.value;
    end else if (tmr.tick && (count_reg != 8'h00)) begin
      count_reg <= count_reg - 8'h01;
    end
  end

  assign tmr.busy = (count_reg != 8'h00);
endmodule
`default_nettype wire

// ---- design/motor_starter_control.sv ----
// Motor starter controller: reversing, star-delta and pole-changing starters.
`timescale 1ns/1ps
`default_nettype none
module motor_starter_control #(
  parameter int TICK_CYCLES = msc_pkg::TICK_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [1:0]  starter_mode,
  input  wire logic [7:0]  cmd_byte0,
  input  wire logic [7:0]  cmd_byte1,
  input  wire logic [5:0]  din,
  input  wire logic [15:0] motor_current,
  input  wire logic        overload_warning,
  input  wire logic        warning_in,
  input  wire logic        checkback_enable,
  input  wire logic        local_enable,
  input  wire logic [1:0]  fault_out_sel,
  input  wire logic        star_delta_switch_mode,
  input  wire logic [7:0]  star_delta_start_time,
  input  wire logic [15:0] switch_current_pct,
  input  wire logic [7:0]  reverse_lockout_time,
  input  wire logic        voltage_dip_enable,
  output logic             relay_out_a,
  output logic             relay_out_b,
  output logic             relay_out_c,
  output logic             aux_supply_output,
  output logic [7:0]       mon_byte0,
  output logic [7:0]       mon_byte1,
  output logic [15:0]      mon_word1,
  output logic             ride_through_enable,
  output logic             emergency_start_armed
);

  ////////////////////////////////////////////////////////////////////////
  // Timer slots, one countdown each
  localparam int TMR_LOCKOUT   = 0;  // Reverse lockout after leaving a run
  localparam int TMR_START     = 1;  // Configured star starting time
  localparam int TMR_MIN_START = 2;  // Fixed floor before delta
  localparam int TMR_CHECKBACK = 3;  // Grace while contactors move
  localparam int NUM_TIMERS    = 4;  // Number of countdowns
  // Last count of the time base prescaler
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////
  // State and time base
  msc_pkg::state_e state_reg;     // Present controller state
  msc_pkg::state_e state_next;    // Next controller state
  msc_pkg::state_e last_run_reg;  // Last direction run, for lockout
  logic [31:0]     tick_cnt_reg;  // Prescaler count
  logic            tick_reg;      // One pulse per time base step

  // Timer carriers and their flattened views
  wire logic [NUM_TIMERS-1:0] timer_load;                // Restart pulses
  wire logic [NUM_TIMERS-1:0] timer_busy;                // Still counting
  wire logic [7:0]            timer_value [NUM_TIMERS];  // Load values

  ////////////////////////////////////////////////////////////////////////
  // Mode decode
  wire logic is_rev  = (starter_mode == msc_pkg::MODE_REVERSING);
  wire logic is_sd   = (starter_mode == msc_pkg::MODE_STAR_DELTA);
  wire logic is_pole = (starter_mode == msc_pkg::MODE_POLE);

  // Local inputs count only when local control is allowed
  wire logic loc_start  = local_enable && din[msc_pkg::DIN_START];
  wire logic loc_speed2 = local_enable && din[msc_pkg::DIN_SPEED2];
  wire logic loc_stop   = local_enable && din[msc_pkg::DIN_STOP];

  // Command decode, local and fieldbus requests merged
  wire logic req_off   = cmd_byte0[msc_pkg::CMD0_OFF] || loc_stop;
  wire logic req_fwd   = cmd_byte0[msc_pkg::CMD0_RUN_FWD] || loc_start;
  wire logic req_rev   = is_rev && (cmd_byte0[msc_pkg::CMD0_RUN_REV] || loc_speed2);
  wire logic req_fast  = is_pole && (cmd_byte1[msc_pkg::CMD1_FAST_FWD] || loc_speed2);
  wire logic fault_rst = cmd_byte0[msc_pkg::CMD0_FAULT_RST];

  ////////////////////////////////////////////////////////////////////////
  // Reverse lockout: only the opposite direction waits
  wire logic lockout_busy = timer_busy[TMR_LOCKOUT];
  wire logic fwd_allowed  = (last_run_reg != msc_pkg::st_rev) || !lockout_busy;
  wire logic rev_allowed  = (last_run_reg != msc_pkg::st_fwd) || !lockout_busy;

  ////////////////////////////////////////////////////////////////////////
  // Star to delta changeover
  // Short settings are raised to the floor rather than refused
  wire logic [7:0] start_ticks = (star_delta_start_time < msc_pkg::MIN_START_TICKS) ?
                                 msc_pkg::MIN_START_TICKS : star_delta_start_time;
  wire logic min_start_done  = !timer_busy[TMR_MIN_START];
  wire logic start_time_done = !timer_busy[TMR_START];
  wire logic current_low     = (motor_current <= switch_current_pct);
  // Current mode still changes over at the starting time as a backstop
  wire logic go_delta = min_start_done &&
                        (star_delta_switch_mode ? (current_low || start_time_done) :
                                                  start_time_done);

  ////////////////////////////////////////////////////////////////////////
  // Contactor checkback on the first digital input
  wire logic contactor_cmd = relay_out_a || relay_out_b || (is_sd && relay_out_c);
  wire logic checkback_bad = checkback_enable && !timer_busy[TMR_CHECKBACK] &&
                             (din[msc_pkg::DIN_CHECKBACK] != contactor_cmd);

  ////////////////////////////////////////////////////////////////////////
  // Next state; every run state falls back to off on a mode change
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      msc_pkg::st_off: begin
        if (checkback_bad) begin
          state_next = msc_pkg::st_fault;
        end else if (req_off) begin
          state_next = msc_pkg::st_off;
        end else if (is_rev && req_fwd && fwd_allowed) begin
          state_next = msc_pkg::st_fwd;
        end else if (req_rev && rev_allowed) begin
          state_next = msc_pkg::st_rev;
        end else if (is_sd && req_fwd) begin
          state_next = msc_pkg::st_star;
        end else if (req_fast) begin
          state_next = msc_pkg::st_speed2;
        end else if (is_pole && req_fwd) begin
          state_next = msc_pkg::st_speed1;
        end
      end
      msc_pkg::st_fwd, msc_pkg::st_rev: begin
        // A direction change always passes through off
        if (checkback_bad) begin
          state_next = msc_pkg::st_fault;
        end else if (req_off || !is_rev) begin
          state_next = msc_pkg::st_off;
        end
      end
      msc_pkg::st_star: begin
        if (checkback_bad) begin
          state_next = msc_pkg::st_fault;
        end else if (req_off || !is_sd) begin
          state_next = msc_pkg::st_off;
        end else if (go_delta) begin
          state_next = msc_pkg::st_delta;
        end
      end
      msc_pkg::st_delta: begin
        if (checkback_bad) begin
          state_next = msc_pkg::st_fault;
        end else if (req_off || !is_sd) begin
          state_next = msc_pkg::st_off;
        end
      end
      msc_pkg::st_speed1: begin
        if (checkback_bad) begin
          state_next = msc_pkg::st_fault;
        end else if (req_off || !is_pole) begin
          state_next = msc_pkg::st_off;
        end else if (req_fast) begin
          state_next = msc_pkg::st_speed2;
        end
      end
      msc_pkg::st_speed2: begin
        if (checkback_bad) begin
          state_next = msc_pkg::st_fault;
        end else if (req_off || !is_pole) begin
          state_next = msc_pkg::st_off;
        end else if (req_fwd && !req_fast) begin
          state_next = msc_pkg::st_speed1;
        end
      end
      msc_pkg::st_fault: begin
        // Only a fault reset leaves the latched fault
        if (fault_rst) begin
          state_next = msc_pkg::st_off;
        end
      end
      default: begin
        state_next = msc_pkg::st_off;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Output selection from the next state, so pairs never overlap
  wire logic fault_next   = (state_next == msc_pkg::st_fault);
  wire logic relay_a_next = (state_next == msc_pkg::st_fwd) ||
                            (state_next == msc_pkg::st_star) ||
                            (state_next == msc_pkg::st_speed1);
  wire logic relay_b_next = (state_next == msc_pkg::st_rev) ||
                            (state_next == msc_pkg::st_delta) ||
                            (state_next == msc_pkg::st_speed2);
  wire logic sd_main_next = (state_next == msc_pkg::st_star) ||
                            (state_next == msc_pkg::st_delta);
  // Relay c is the main contactor in star-delta, never the fault output there
  wire logic relay_c_fault = (fault_out_sel == msc_pkg::FAULT_OUT_RELAY) && !is_sd;
  wire logic aux_fault     = (fault_out_sel == msc_pkg::FAULT_OUT_AUX);
  wire logic relay_c_next  = is_sd ? sd_main_next :
                             (relay_c_fault ? fault_next :
                                              cmd_byte1[msc_pkg::CMD1_RELAY_C]);
  wire logic aux_next      = aux_fault ? fault_next :
                                         cmd_byte1[msc_pkg::CMD1_AUX_OUT];
  // Any contactor move restarts the checkback grace
  wire logic contactor_change = (relay_a_next != relay_out_a) ||
                                (relay_b_next != relay_out_b) ||
                                (is_sd && (relay_c_next != relay_out_c));

  ////////////////////////////////////////////////////////////////////////
  // Timer requests
  wire logic leaving_dir   = ((state_reg == msc_pkg::st_fwd) || (state_reg == msc_pkg::st_rev)) &&
                             (state_next != state_reg);
  wire logic entering_star = (state_next == msc_pkg::st_star) &&
                             (state_reg != msc_pkg::st_star);
  // Bit order follows the slot numbers: checkback, floor, start, lockout
  assign timer_load = {contactor_change, entering_star, entering_star, leaving_dir};
  assign timer_value[TMR_LOCKOUT]   = reverse_lockout_time;
  assign timer_value[TMR_START]     = start_ticks;
  assign timer_value[TMR_MIN_START] = msc_pkg::MIN_START_TICKS;
  assign timer_value[TMR_CHECKBACK] = msc_pkg::CHECKBACK_TICKS;

  ////////////////////////////////////////////////////////////////////////
  // Monitoring selection
  wire logic run_fwd_next = (state_next == msc_pkg::st_fwd) || sd_main_next ||
                            (state_next == msc_pkg::st_speed1);
  wire logic run_rev_next = (state_next == msc_pkg::st_rev);
  wire logic off_next     = (state_next == msc_pkg::st_off);
  wire logic lockout_flag = is_rev && lockout_busy;
  // Current word is clamped to the reporting ceiling
  wire logic [15:0] current_clamped = (motor_current > msc_pkg::CURRENT_MAX_PCT) ?
                                      msc_pkg::CURRENT_MAX_PCT : motor_current;
  wire logic [15:0] word1_next = is_rev ? '0 : current_clamped;
  wire logic ride_next = voltage_dip_enable && !is_pole;
  logic [7:0] mon0_next;  // Next monitoring byte 0
  logic [7:0] mon1_next;  // Next monitoring byte 1

  // Monitoring byte 0 assembly
  always_comb begin
    mon0_next = '0;
    mon0_next[msc_pkg::MON0_RUN_REV]  = run_rev_next;
    mon0_next[msc_pkg::MON0_OFF]      = off_next;
    mon0_next[msc_pkg::MON0_RUN_FWD]  = run_fwd_next;
    mon0_next[msc_pkg::MON0_OVERLOAD] = overload_warning;
    mon0_next[msc_pkg::MON0_LOCKOUT]  = lockout_flag;
    mon0_next[msc_pkg::MON0_LOCAL]    = local_enable;
    mon0_next[msc_pkg::MON0_FAULT]    = fault_next;
    mon0_next[msc_pkg::MON0_WARNING]  = warning_in || overload_warning;
  end

  // Monitoring byte 1 assembly: input mirror and fast run
  always_comb begin
    mon1_next = '0;
    mon1_next[msc_pkg::MON1_DIN_LSB +: $bits(din)] = din;
    mon1_next[msc_pkg::MON1_FAST_FWD] = (state_next == msc_pkg::st_speed2);
  end

  ////////////////////////////////////////////////////////////////////////
  // Time base prescaler, one pulse every TICK_CYCLES clocks
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg == TICK_LAST) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
      tick_reg     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Countdown timers, one per slot
  timer_if tmr [NUM_TIMERS] ();
  for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_timer
    assign tmr[i].load  = timer_load[i];
    assign tmr[i].value = timer_value[i];
    assign tmr[i].tick  = tick_reg;
    assign timer_busy[i] = tmr[i].busy;
    tick_countdown i_tick_countdown (
      .mclk (mclk),
      .rst  (rst),
      .tmr  (tmr[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Controller state and remembered direction
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg    <= msc_pkg::st_off;
      last_run_reg <= msc_pkg::st_off;
    end else begin
      state_reg <= state_next;
      // Same-direction restart ignores the lockout, so remember the last run
      if ((state_next == msc_pkg::st_fwd) || (state_next == msc_pkg::st_rev)) begin
        last_run_reg <= state_next;
      end
    end
  end

  // Relay and supply outputs, registered
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      relay_out_a       <= 1'b0;
      relay_out_b       <= 1'b0;
      relay_out_c       <= 1'b0;
      aux_supply_output <= 1'b0;
    end else begin
      relay_out_a       <= relay_a_next;
      relay_out_b       <= relay_b_next;
      relay_out_c       <= relay_c_next;
      aux_supply_output <= aux_next;
    end
  end

  // Monitoring and status outputs, registered
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mon_byte0             <= 8'h00;
      mon_byte1             <= 8'h00;
      mon_word1             <= 16'h0000;
      ride_through_enable   <= 1'b0;
      emergency_start_armed <= 1'b0;
    end else begin
      mon_byte0             <= mon0_next;
      mon_byte1             <= mon1_next;
      mon_word1             <= word1_next;
      ride_through_enable   <= ride_next;
      emergency_start_armed <= cmd_byte0[msc_pkg::CMD0_EMERGENCY];
    end
  end
endmodule
`default_nettype wire

// ---- dv/msc_master.sv ----
// Fieldbus master model holding the command bytes between updates.
`timescale 1ns/1ps
`default_nettype none
module msc_master (
  input  wire logic        mclk,
  input  wire logic [15:0] req,
  output logic [7:0]       cmd_byte0,
  output logic [7:0]       cmd_byte1
);
  always_ff @(posedge mclk) {cmd_byte1, cmd_byte0} <= req;
endmodule
`default_nettype wire

// ---- dv/msc_checker.sv ----
// Port checker for the motor starter.
`timescale 1ns/1ps
`default_nettype none
module msc_checker (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [1:0]  starter_mode,
  input wire logic [5:0]  din,
  input wire logic        warning_in,
  input wire logic        overload_warning,
  input wire logic        relay_out_a,
  input wire logic        relay_out_b,
  input wire logic        ride_through_enable,
  input wire logic [7:0]  mon_byte0,
  input wire logic [7:0]  mon_byte1,
  input wire logic [15:0] mon_word1
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Forward running in reversing mode
  sequence seq_fwd_run;
    relay_out_a && (starter_mode == msc_pkg::MODE_REVERSING);
  endsequence
  // Reverse contactor just closed
  sequence seq_rev_rise;
    $rose(relay_out_b);
  endsequence
  a_pair_excl: assert property (!(relay_out_a && relay_out_b)) else $error("pair on");
  a_cur_cap: assert property (mon_word1 <= msc_pkg::CURRENT_MAX_PCT) else $error("over");
  a_no_direct_rev: assert property (not (seq_fwd_run ##1 seq_rev_rise)) else $error("direct reverse");
  a_fault_drop: assert property (mon_byte0[msc_pkg::MON0_FAULT] |-> !relay_out_a && !relay_out_b) else $error("fault with contactor");
  a_ride_pole: assert property ((starter_mode == msc_pkg::MODE_POLE) |=> !ride_through_enable) else $error("ride in pole mode");
  a_din_mirror: assert property (1'b1 |=> (mon_byte1[7:2] == $past(din))) else $error("input mirror");
  a_warn_sum: assert property (1'b1 |=> (mon_byte0[msc_pkg::MON0_WARNING] == ($past(warning_in) || $past(overload_warning)))) else $error("warning sum");
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Motor starter testbench.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk=0, rst=1, overload_warning=0, warning_in=0, voltage_dip_enable=1, relay_out_a;
  logic checkback_enable=0, local_enable=0, star_delta_switch_mode=0, relay_out_b, relay_out_c;
  logic aux_supply_output, ride_through_enable, emergency_start_armed;
  logic [1:0] starter_mode=0, fault_out_sel=0;
  logic [5:0] din=0;
  logic [7:0] cmd_byte0, cmd_byte1, mon_byte0, mon_byte1, reverse_lockout_time=1;
  logic [7:0] star_delta_start_time=8'h0A;
  logic [15:0] motor_current=0, switch_current_pct=0, mon_word1, req=0;
  int failures=0, samples_checked=0, seed=32'h5DB1A7EB;
  wire logic [7:0] rl = {5'h00, relay_out_c, relay_out_b, relay_out_a};
  motor_starter_control #(.TICK_CYCLES(4)) i_motor_starter_control (
    .mclk(mclk), .rst(rst), .starter_mode(starter_mode), .cmd_byte0(cmd_byte0),
    .cmd_byte1(cmd_byte1), .din(din), .motor_current(motor_current),
    .overload_warning(overload_warning), .warning_in(warning_in),
    .checkback_enable(checkback_enable), .local_enable(local_enable),
    .fault_out_sel(fault_out_sel), .star_delta_switch_mode(star_delta_switch_mode),
    .star_delta_start_time(star_delta_start_time), .switch_current_pct(switch_current_pct),
    .reverse_lockout_time(reverse_lockout_time), .voltage_dip_enable(voltage_dip_enable),
    .relay_out_a(relay_out_a), .relay_out_b(relay_out_b), .relay_out_c(relay_out_c),
    .aux_supply_output(aux_supply_output), .mon_byte0(mon_byte0), .mon_byte1(mon_byte1),
    .mon_word1(mon_word1), .ride_through_enable(ride_through_enable),
    .emergency_start_armed(emergency_start_armed));
  msc_master i_msc_master (.mclk(mclk), .req(req), .cmd_byte0(cmd_byte0), .cmd_byte1(cmd_byte1));
  // Reported current is clamped at 800 percent
  function automatic logic [15:0] exp_current(logic [15:0] raw);
    return (raw > 16'h0320) ? 16'h0320 : raw;
  endfunction
  initial forever #4 mclk = ~mclk;
  initial #20000 begin failures++; conclude(); end
  task automatic ck(string n, logic [7:0] e, logic [7:0] s);
    samples_checked++;
    if (s !== e) begin failures++; $display("unexpected %s expected %h seen %h", n, e, s); end
  endtask
  task automatic go(logic [15:0] r, int n); req = r; repeat (n) @(posedge mclk); #1; endtask
  task automatic conclude();
    $display("%0d checks %0d failures", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    #1 rst = 0;
    repeat (20) begin
      {din, motor_current} = 22'($random(seed));
      go({8'($random(seed)) & 8'h90, 8'h02}, 4);
      ck("din", din, mon_byte1[7:2]);
      ck("out", {6'h00, cmd_byte1[7], cmd_byte1[4]}, {6'h00, relay_out_c, aux_supply_output});
    end
    go(16'h0004, 8); go(16'h0001, 8); ck("lock", 8'h01, rl);
    go(16'h0002, 16); go(16'h0001, 8); ck("rev", 8'h02, rl);
    ck("mon_rev", 8'h01, mon_byte0);
    go(16'h0002, 8); starter_mode = 2'h1; go(16'h0004, 8); ck("star", 8'h05, rl);
    motor_current = 16'($random(seed));
    go(16'h0004, 48); ck("delta", 8'h06, rl);
    ck("mon_sd", 8'h04, mon_byte0);
    ck("cur_hi", exp_current(motor_current) >> 8, mon_word1[15:8]);
    ck("cur_lo", exp_current(motor_current) & 16'h00FF, mon_word1[7:0]);
    go(16'h0002, 8); starter_mode = 2'h2; go(16'h0200, 8);
    ck("spd2", 8'h02, rl | {ride_through_enable, 7'h00});
    ck("fast", 8'h02, mon_byte1 & 8'h02);
    checkback_enable = 1; din = 6'h00; go(16'h0200, 24);
    ck("fault", 8'h40, mon_byte0 & 8'h40);
    ck("drop", 8'h00, rl);
    checkback_enable = 0; go(16'h0040, 8);
    ck("clear", 8'h00, rl);
    ck("flt_off", 8'h02, mon_byte0 & 8'h42);
    go(16'h0010, 4); ck("emg", 8'h01, {7'h00, emergency_start_armed});
    conclude();
  end
endmodule
bind motor_starter_control msc_checker i_msc_checker (
  .mclk(mclk), .rst(rst), .starter_mode(starter_mode), .din(din), .warning_in(warning_in),
  .overload_warning(overload_warning), .relay_out_a(relay_out_a), .relay_out_b(relay_out_b),
  .ride_through_enable(ride_through_enable), .mon_byte0(mon_byte0), .mon_byte1(mon_byte1),
  .mon_word1(mon_word1));
`default_nettype wire
